// ==== verilog/crs_reset_seq.sv ====
// Reset sequencer top: stretches the system reset, captures straps and
// drives the processor soft-init output.
// Assumes reset inputs are synchronous to clk_i and the host bus decoder
// supplies a one-cycle shutdown strobe and configuration write strobes.
`timescale 1ns/1ps
`include "crs_map.svh"
module crs_reset_seq
    import crs_pkg::*;
#(
    parameter int STRETCH_CYC = `CRS_STRETCH_CYC,
    parameter int STRAP_W = 8
)
(
    input wire logic clk_i, // Host clock.
    input wire logic reset_i, // Asynchronous reset, high.
    input wire logic system_reset_in_n_i, // System reset input, low.
    input wire logic [STRAP_W-1:0] strap_i, // Clock-enable pin straps.
    input wire logic shutdown_i, // Processor shutdown cycle strobe.
    input wire logic cfg_wr_i, // Configuration write strobe.
    input wire logic cfg_rd_i, // Configuration read strobe.
    input wire logic [7:0] cfg_addr_i, // Configuration offset.
    input wire logic [7:0] cfg_wdata_i, // Configuration write data.
    output logic [7:0] cfg_rdata_o, // Configuration read data.
    output logic cfg_hit_o, // Offset decoded here.
    output logic no_data_resp_o, // End shutdown cycle with no data.
    output logic processor_reset_out_n_o, // Processor reset, low.
    output logic auxiliary_reset_out_n_o, // Auxiliary reset, low.
    output logic processor_init_n_o, // Processor soft-init, low.
    output logic bist_request_o, // Self-test request to processor.
    output logic [STRAP_W-1:0] strap_o // Captured straps.
);
    localparam int CW = $clog2(STRETCH_CYC + 1);
    typedef struct packed
    {
        crs_state_t state;
        logic [CW-1:0] count;
        logic rst_in_q;
        logic [7:0] ctrl;
        logic [STRAP_W-1:0] straps;
        logic proc_rst;
        logic aux_rst;
        logic no_data;
        logic [7:0] rdata;
        logic [CW:0] high_run;
    } crs_top_t;
    crs_top_t cur;
    crs_top_t next_cur;
    logic ctrl_wr;
    logic soft_trigger;
    logic init_active;
    logic rst_rise;
    // ==========================================================
    // Register decode; a qualifying write to the control offset or a shutdown strobe is the soft-init source.
    assign ctrl_wr = cfg_wr_i && (cfg_addr_i == `CRS_CTRL_OFFSET);
    assign cfg_hit_o = cfg_addr_i == `CRS_CTRL_OFFSET;
    assign rst_rise = system_reset_in_n_i && !cur.rst_in_q;
    assign soft_trigger = shutdown_i
        || (ctrl_wr && !cfg_wdata_i[`CRS_BIT_HARD_SEL]
            && cfg_wdata_i[`CRS_BIT_BIST_REQ]
            && cfg_wdata_i[`CRS_BIT_PROC_RESET_REQ]
            && !cur.ctrl[`CRS_BIT_PROC_RESET_REQ]);
    // ==========================================================
    // Sequencer. Soft-init never enters this path, so system resets stay put.
    always_comb
    begin
        next_cur = cur;
        next_cur.rst_in_q = system_reset_in_n_i;
        next_cur.no_data = shutdown_i;
        if (ctrl_wr)
            next_cur.ctrl = cfg_wdata_i;
        if (cfg_rd_i)
            next_cur.rdata = (cfg_addr_i == `CRS_CTRL_OFFSET) ? cur.ctrl : 8'h00;
        if (rst_rise)
            next_cur.straps = strap_i;
        // Check-only run length of the high reset input; one bit wider to reach STRETCH_CYC + 1, and it saturates at all ones.
        if (!system_reset_in_n_i)
            next_cur.high_run = '0;
        else if (cur.high_run != '1)
            next_cur.high_run = cur.high_run + (CW+1)'(1);
        if (!system_reset_in_n_i)
        begin
            // Any fall, even mid-stretch, restarts the whole sequence.
            next_cur.state = CRS_ST_HOLD;
            next_cur.count = '0;
            next_cur.proc_rst = 1'b1;
            next_cur.aux_rst = 1'b1;
            next_cur.ctrl = `CRS_CTRL_RESET;
        end
        else
        begin
            case (cur.state)
                CRS_ST_HOLD:
                begin
                    next_cur.state = CRS_ST_STRETCH;
                    next_cur.count = CW'(1);
                end
                CRS_ST_STRETCH:
                begin
                    if (cur.count >= CW'(STRETCH_CYC))
                    begin
                        next_cur.proc_rst = 1'b0;
                        next_cur.state = CRS_ST_AUX;
                        next_cur.count = CW'(1);
                    end
                    else
                        next_cur.count = cur.count + CW'(1);
                end
                CRS_ST_AUX:
                begin
                    if (cur.count >= CW'(`CRS_AUX_EXTRA_CYC))
                    begin
                        next_cur.aux_rst = 1'b0;
                        next_cur.state = CRS_ST_RUN;
                    end
                    else
                        next_cur.count = cur.count + CW'(1);
                end
                CRS_ST_RUN:
                begin
                    next_cur.count = '0;
                end
                default:
                begin
                    next_cur.state = CRS_ST_HOLD;
                end
            endcase
        end
    end
    // Reset state is constant; output flops change only on clk_i or the rise of reset_i.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cur <= '0;
            cur.state <= CRS_ST_HOLD;
            cur.proc_rst <= 1'b1;
            cur.aux_rst <= 1'b1;
        end
        else
            cur <= next_cur;
    end
    // ==========================================================
    // Soft-init pulse generator.
    crs_init_pulse #(
        .WIDTH(`CRS_INIT_MIN_CYC)
    ) u_init (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .trigger_i(soft_trigger),
        .init_active_o(init_active)
    );
    assign processor_reset_out_n_o = !cur.proc_rst;
    assign auxiliary_reset_out_n_o = !cur.aux_rst;
    assign processor_init_n_o = !init_active;
    assign no_data_resp_o = cur.no_data;
    assign cfg_rdata_o = cur.rdata;
    assign bist_request_o = cur.ctrl[`CRS_BIT_BIST_REQ] && cur.ctrl[`CRS_BIT_HARD_SEL];
    assign strap_o = cur.straps;
    // ==========================================================
    // Checks. Each one watches ports or state of this block only.

    // Both resets follow the reset input down on the next clock.
    a_reset_in_low: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !system_reset_in_n_i |=> !processor_reset_out_n_o && !auxiliary_reset_out_n_o)
        else $error("resets not active while reset input low");

    // The auxiliary reset is never released while the processor is held.
    a_aux_covers_proc: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !processor_reset_out_n_o |-> !auxiliary_reset_out_n_o)
        else $error("auxiliary reset released before processor reset");

    // Two clocks after the processor reset rises, the auxiliary one follows.
    a_aux_after_proc: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ($rose(processor_reset_out_n_o) && system_reset_in_n_i) ##1 system_reset_in_n_i
        |-> !auxiliary_reset_out_n_o ##1 auxiliary_reset_out_n_o)
        else $error("auxiliary reset not released two clocks after processor");

    // The processor reset rises only after a full stretch of high input.
    a_proc_held: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $rose(processor_reset_out_n_o) |-> cur.high_run == (CW+1)'(STRETCH_CYC + 1))
        else $error("processor reset released without stretch");

    // A fall of the reset input mid-stretch restarts the count from zero.
    a_restart: assert property (
        @(posedge clk_i) disable iff (reset_i)
        cur.state == CRS_ST_STRETCH && !system_reset_in_n_i
        |=> cur.state == CRS_ST_HOLD && cur.count == '0)
        else $error("stretch count not restarted");

    // A soft-init pulse leaves the system resets where they were.
    a_soft_no_hard: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $fell(processor_init_n_o) && auxiliary_reset_out_n_o && system_reset_in_n_i
        |=> auxiliary_reset_out_n_o && processor_reset_out_n_o)
        else $error("soft reset disturbed system resets");

    // A shutdown cycle is ended with no data and starts the init pulse.
    a_shutdown_resp: assert property (
        @(posedge clk_i) disable iff (reset_i)
        shutdown_i |=> no_data_resp_o && !processor_init_n_o)
        else $error("shutdown not answered with no-data and init");

    // The no-data response never appears without a shutdown cycle behind it.
    a_no_data_src: assert property (
        @(posedge clk_i) disable iff (reset_i)
        no_data_resp_o |-> $past(shutdown_i))
        else $error("no-data response without shutdown cycle");

    // A qualifying control write gives at least four clocks of init.
    a_ctrl_init: assert property (
        @(posedge clk_i) disable iff (reset_i)
        soft_trigger && !shutdown_i |=> !processor_init_n_o [*4])
        else $error("control write init pulse too short");

    // Init starts only after a shutdown or a write that sets bit 2 with bit 3 clear.
    a_init_source: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $fell(processor_init_n_o) |-> $past(shutdown_i)
            || ($past(cfg_wr_i) && $past(cfg_wdata_i[`CRS_BIT_PROC_RESET_REQ])
            && !$past(cfg_wdata_i[`CRS_BIT_HARD_SEL])))
        else $error("init pulse without a trigger");

    // Straps are only loaded at the rising edge of the reset input.
    a_strap_hold: assert property (
        @(posedge clk_i) disable iff (reset_i)
        system_reset_in_n_i && cur.rst_in_q |=> $stable(strap_o))
        else $error("straps changed outside reset release");

    // The rising edge loads the strap pins as they stood on that clock.
    a_strap_capture: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rst_rise |=> strap_o == $past(strap_i))
        else $error("straps not captured at reset release");
endmodule : crs_reset_seq

// ==== verilog/crs_map.svh ====
// Constants of the processor reset and soft-init sequencer.
// Assumes a 40 MHz clk_i; the stretch time is in microseconds, the clock in MHz, the other timing constants in clocks.
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// ==========================================================
// Register map and fields.
`define CRS_CTRL_OFFSET 8'h93
`define CRS_CTRL_RESET 8'h00
`define CRS_BIT_BIST_REQ 1
`define CRS_BIT_PROC_RESET_REQ 2
`define CRS_BIT_HARD_SEL 3
// ==========================================================
// Timing.
`define CRS_CLK_MHZ 40
`define CRS_STRETCH_US 1000
`define CRS_STRETCH_CYC (`CRS_STRETCH_US * `CRS_CLK_MHZ)
`define CRS_AUX_EXTRA_CYC 2
`define CRS_INIT_MIN_CYC 4
`endif

// ==== verilog/crs_pkg.sv ====
// Types shared by the reset sequencer modules.
// Assumes crs_map.svh supplies the numeric constants.
package crs_pkg;
    typedef enum logic [1:0]
    {
        CRS_ST_HOLD = 2'b00,
        CRS_ST_STRETCH = 2'b01,
        CRS_ST_AUX = 2'b10,
        CRS_ST_RUN = 2'b11
    } crs_state_t;
endpackage : crs_pkg

// ==== verilog/crs_init_pulse.sv ====
// Soft-init pulse stretcher.
// Assumes single-cycle triggers in the clk_i domain.
`timescale 1ns/1ps
`include "crs_map.svh"
module crs_init_pulse
    import crs_pkg::*;
#(
    parameter int WIDTH = `CRS_INIT_MIN_CYC
)
(
    input wire logic clk_i, // Host clock.
    input wire logic reset_i, // Asynchronous reset, high.
    input wire logic trigger_i, // Start or restart the pulse.
    output logic init_active_o // Soft-init active, high.
);
    typedef struct packed
    {
        logic [3:0] count;
        logic active;
    } crs_pulse_t;
    crs_pulse_t cur;
    crs_pulse_t next_cur;
    // ==========================================================
    // Counter: a retrigger restarts the full width, so pulses never shorten.
    always_comb
    begin
        next_cur = cur;
        if (trigger_i)
        begin
            next_cur.active = 1'b1;
            next_cur.count = 4'(WIDTH - 1);
        end
        else if (cur.active)
        begin
            if (cur.count == 4'h0)
                next_cur.active = 1'b0;
            else
                next_cur.count = cur.count - 4'h1;
        end
    end
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            cur <= '0;
        else
            cur <= next_cur;
    end
    assign init_active_o = cur.active;
    // ==========================================================
    // A trigger yields at least WIDTH active cycles.
    a_init_min_width: assert property (
        @(posedge clk_i) disable iff (reset_i)
        trigger_i |=> init_active_o [*4])
        else $error("init pulse shorter than four clocks");
endmodule : crs_init_pulse

// ==== tb/crs_bridge_model.sv ====
// Behavioural model of the I/O bridge that drives the system reset input.
// Assumes the bench supplies a free-running host clock and one-cycle requests.
`timescale 1ns/1ps
module crs_bridge_model
#(
    parameter int HOLD_CYC = 10
)
(
    input wire logic clk_i, // Host clock, never stopped.
    input wire logic req_i, // Hard reset request, one cycle.
    output logic system_reset_in_n_o // System reset input of the device, low.
);
    int cnt = 0;
    // =====================================================================
    // Hard reset hold
    // Each request restarts the low time; the line starts low at power-up.
    always @(posedge clk_i)
    begin
        if (req_i)
            cnt <= 0;
        else if (cnt < HOLD_CYC)
            cnt <= cnt + 1;
    end
    assign system_reset_in_n_o = (cnt >= HOLD_CYC);
endmodule : crs_bridge_model

// ==== tb/crs_reset_seq_tb.sv ====
// Self-checking bench for the reset sequencer with a bridge model.
// Assumes the design files and crs_map.svh are on the include path.
`timescale 1ns/1ps
`include "crs_map.svh"
module crs_reset_seq_tb;
    import crs_pkg::*;
    localparam int SC = 20;
    logic clk_i = 0, reset_i = 1, req = 0, sys_n, shutdown_i = 0, cfg_wr_i = 0, cfg_rd_i = 0;
    logic [7:0] strap_i = 8'h00, cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o, strap_o;
    logic cfg_hit_o, no_data_resp_o, proc_n, aux_n, processor_init_n_o, bist_request_o;
    logic [31:0] seed = 32'h0000000f;
    logic [7:0] notes[$], d;
    logic [7:0] wvals[7] = '{8'h00, 8'h06, 8'h06, 8'h00, 8'h04, 8'h08, 8'h0e};
    int init_q[$], fails = 0, tests_run = 0, cyc = 0, ilen = 0;
    logic rd_s, sd_s;
    always #12.5 clk_i = ~clk_i;
    crs_bridge_model #(.HOLD_CYC(10)) i_crs_bridge_model (.clk_i(clk_i), .req_i(req),
        .system_reset_in_n_o(sys_n));
    crs_reset_seq #(.STRETCH_CYC(SC), .STRAP_W(8)) i_crs_reset_seq (.clk_i(clk_i),
        .reset_i(reset_i), .system_reset_in_n_i(sys_n), .strap_i(strap_i),
        .shutdown_i(shutdown_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .cfg_hit_o(cfg_hit_o), .no_data_resp_o(no_data_resp_o),
        .processor_reset_out_n_o(proc_n), .auxiliary_reset_out_n_o(aux_n),
        .processor_init_n_o(processor_init_n_o), .bist_request_o(bist_request_o),
        .strap_o(strap_o));
    // =====================================================================
    // Helpers
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_len(input string what, input int exp, input int got);
        tests_run++;
        if (got != exp)
        begin
            fails++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_len
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic kick(input logic [7:0] s);
        @(posedge clk_i);
        strap_i <= s;
        req <= 1'b1;
        @(posedge clk_i);
        req <= 1'b0;
    endtask : kick
    task automatic wait_high();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        while (sys_n !== 1'b1 && n < 50);
    endtask : wait_high
    // Counts edges from the release; straps change right at the capture edge.
    task automatic measure(input logic [7:0] s);
        int n, m;
        n = 0;
        m = 0;
        chk_val("resets while input low", 8'h00, {6'h00, proc_n, aux_n});
        while (aux_n !== 1'b1 && m < 60)
        begin
            @(posedge clk_i);
            strap_i <= ~s;
            #1;
            m++;
            if (proc_n !== 1'b1)
                n = m;
        end
        chk_len("processor reset stretch", SC, n);
        chk_len("auxiliary reset stretch", SC + `CRS_AUX_EXTRA_CYC, m - 1);
        chk_val("captured straps", s, strap_o);
    endtask : measure
    // Access tasks note the expected outcome before the design can answer.
    task automatic cfg_write(input logic [7:0] a, input logic [7:0] v, input bit pulse);
        @(posedge clk_i);
        cfg_addr_i <= a;
        cfg_wdata_i <= v;
        cfg_wr_i <= 1'b1;
        if (pulse)
            init_q.push_back(`CRS_INIT_MIN_CYC);
        @(posedge clk_i);
        cfg_wr_i <= 1'b0;
    endtask : cfg_write
    task automatic cfg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        cfg_addr_i <= a;
        cfg_rd_i <= 1'b1;
        notes.push_back(exp);
        #1 chk_val("offset decode", {7'h00, a == 8'h93}, {7'h00, cfg_hit_o});
        @(posedge clk_i);
        cfg_rd_i <= 1'b0;
    endtask : cfg_read
    // =====================================================================
    // Monitor
    // Strobes are read at the edge itself, before this edge's updates land.
    always @(posedge clk_i)
    begin
        rd_s = cfg_rd_i;
        sd_s = shutdown_i;
        cyc++;
        if (cyc == 2000)
        begin
            fails++;
            end_sim();
        end
        #1;
        if (!reset_i)
        begin
            chk_val("no data response", {7'h00, sd_s}, {7'h00, no_data_resp_o});
            if (rd_s)
                chk_val("read data", notes.size() ? notes.pop_front() : 8'hxx, cfg_rdata_o);
            if (processor_init_n_o === 1'b0)
                ilen++;
            else if (ilen > 0)
            begin
                chk_len("init width", init_q.size() ? init_q.pop_front() : 0, ilen);
                ilen = 0;
            end
        end
    end
    // =====================================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        kick(rnd());
        wait_high();
        measure(strap_i);
        kick(rnd());
        wait_high();
        // Drop the input just before the stretch would expire.
        repeat (SC - 4) @(posedge clk_i);
        d = rnd();
        kick(d);
        repeat (3) @(posedge clk_i);
        #1 chk_val("restart drops resets", 8'h00, {6'h00, proc_n, aux_n});
        wait_high();
        measure(d);
        foreach (wvals[i])
        begin
            d = wvals[i];
            cfg_write(8'h93, d, i == 1);
            cfg_read(8'h93, d);
            chk_val("self-test request", {7'h00, d[1] & d[3]}, {7'h00, bist_request_o});
        end
        // Self-test is left requested, so software follows with a hard reset.
        kick(strap_i);
        wait_high();
        chk_val("self-test after hard reset", 8'h00, {7'h00, bist_request_o});
        repeat (4)
        begin
            d = rnd() & 8'hfb;
            cfg_write(8'h93, d, 1'b0);
            cfg_read(8'h93, d);
        end
        cfg_write(8'h92, 8'h06, 1'b0);
        cfg_read(8'h92, 8'h00);
        repeat (2)
        begin
            @(posedge clk_i);
            shutdown_i <= 1'b1;
            init_q.push_back(`CRS_INIT_MIN_CYC);
            @(posedge clk_i);
            shutdown_i <= 1'b0;
            repeat (8) @(posedge clk_i);
        end
        #1 chk_val("resets kept off", 8'h03, {6'h00, proc_n, aux_n});
        chk_len("pending notes", 0, notes.size() + init_q.size());
        end_sim();
    end
endmodule : crs_reset_seq_tb
